// *** inc/swsb_defs.svh ***
// Purpose: Shared constants for the single-wire sensor bus slave.
// Assumes: 50 MHz ref_clk; times held in ns, counts derived here.
// Notes:   Counts round up from their time so no class edge is early.
`ifndef SWSB_DEFS_SVH
`define SWSB_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SWSB_CLK_NS 20
`define SWSB_CYC(ns) (((ns) + `SWSB_CLK_NS - 1) / `SWSB_CLK_NS)
`define SWSB_CNT_W 13
`define SWSB_T01_NS 7000
`define SWSB_T1S_NS 20000
`define SWSB_TSA_NS 50000
`define SWSB_TAR_NS 80000
`define SWSB_TINACT_NS 2000
`define SWSB_TOUT1_NS 14000
`define SWSB_TATTN_NS 60000

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SWSB_DEV_W 3
`define SWSB_IA_W 5
`define SWSB_BCAST 3'h0
`define SWSB_W16_LAST 5'd15
`define SWSB_W8_LAST 5'd7
`define SWSB_ATTN_BITS 4'd14
`define SWSB_WIDE_MASK 32'h0000_00f0
`define SWSB_IA_STATUS 5'h01
`define SWSB_IA_DEVCTL 5'h02
`define SWSB_DC_ATTN 0
`define SWSB_ST_FUNC 0
`define SWSB_ST_BER 1

// ----------------------------------------------------------------------
// Software register map
// ----------------------------------------------------------------------
`define SWSB_A_CTRL 8'h00
`define SWSB_A_STAT 8'h04
`define SWSB_A_EVENT 8'h08
`define SWSB_A_FRAMES 8'h0c
`define SWSB_DEVNO_RST 3'h1

`endif

// *** inc/swsb_pkg.sv ***
// Purpose: Types for the single-wire sensor bus slave.
// Assumes: Included with swsb_defs.svh.
// Notes:   Gray codes along the normal frame path.
package swsb_pkg;

// ----------------------------------------------------------------------
// Frame states and pulse classes
// ----------------------------------------------------------------------
typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_DEV = 3'h1,
    S_ADDR = 3'h3,
    S_DIR = 3'h2,
    S_DATA = 3'h6,
    S_PAR = 3'h7,
    S_ACK = 3'h5,
    S_SKIP = 3'h4
} swsb_fstate_t;

typedef enum logic [2:0] {
    PC_NONE = 3'h0,
    PC_ZERO = 3'h1,
    PC_ONE = 3'h2,
    PC_START = 3'h3,
    PC_ATTN = 3'h4,
    PC_RESET = 3'h5
} swsb_pclass_t;

// ----------------------------------------------------------------------
// Carriers
// ----------------------------------------------------------------------
typedef struct packed {
    swsb_pclass_t cls;
    logic fall;
    logic idle;
} swsb_pulse_t;

typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
} swsb_ahb_in_t;

endpackage : swsb_pkg

// *** verilog/swsb_pulse_meter.sv ***
// Purpose: Measures each low pulse on the wire and classifies it.
// Assumes: lineIn is synchronous to ref_clk.
// Notes:   Class is reported one cycle after the rising edge.
`timescale 1ns/10ps
`include "swsb_defs.svh"
module swsb_pulse_meter #(
    parameter int CW = `SWSB_CNT_W,
    parameter int C01 = `SWSB_CYC(`SWSB_T01_NS),
    parameter int C1S = `SWSB_CYC(`SWSB_T1S_NS),
    parameter int CSA = `SWSB_CYC(`SWSB_TSA_NS),
    parameter int CAR = `SWSB_CYC(`SWSB_TAR_NS),
    parameter int CIN = `SWSB_CYC(`SWSB_TINACT_NS)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lineIn,
    output swsb_pkg::swsb_pulse_t pulse
);
    import swsb_pkg::*;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic prev;
        swsb_pulse_t p;
    } swsb_meter_st_t;

    swsb_meter_st_t q, d;

    // ------------------------------------------------------------------
    // Length counter and classification
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        d.prev = lineIn;
        d.p.fall = 1'b0;
        d.p.cls = PC_NONE;
        if (q.cnt != {CW{1'b1}}) begin
            d.cnt = q.cnt + 1'b1; // Saturates: reset has no upper bound
        end
        if (!lineIn) begin
            d.p.idle = 1'b0;
            if (q.prev) begin
                d.p.fall = 1'b1;
                d.cnt = '0;
            end
        end else if (!q.prev) begin
            d.cnt = '0; // Class by duration
            if (q.cnt < CW'(C01)) d.p.cls = PC_ZERO;
            else if (q.cnt < CW'(C1S)) d.p.cls = PC_ONE;
            else if (q.cnt < CW'(CSA)) d.p.cls = PC_START;
            else if (q.cnt < CW'(CAR)) d.p.cls = PC_ATTN;
            else d.p.cls = PC_RESET;
        end else if (q.cnt >= CW'(CIN)) begin
            d.p.idle = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign pulse = q.p;

endmodule : swsb_pulse_meter

// *** verilog/swsb_low_driver.sv ***
// Purpose: Pulls the wire low for a requested number of cycles.
// Assumes: Requests while busy are dropped by the caller.
// Notes:   Enable comes straight from a flip-flop.
`timescale 1ns/10ps
module swsb_low_driver #(
    parameter int CW = 13
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [CW-1:0] len,
    output logic busy,
    output logic drvOe
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic oe;
    } swsb_drv_st_t;

    swsb_drv_st_t q, d;

    // ------------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        if (go && q.cnt == '0) begin
            d.cnt = len;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - 1'b1;
        end
        d.oe = d.cnt != '0;
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign busy = q.cnt != '0;
    assign drvOe = q.oe;

endmodule : swsb_low_driver

// *** verilog/swsb_slave.sv ***
// Purpose: Transaction layer of a single-wire sensor bus slave.
// Assumes: One master; wire inputs synchronous to ref_clk.
// Notes:   Open drain: lineOut is always low, lineOe drives it.
`timescale 1ns/10ps
`include "swsb_defs.svh"
module swsb_slave #(
    parameter int IAW = `SWSB_IA_W,
    parameter logic [31:0] WIDE_MASK = `SWSB_WIDE_MASK,
    parameter int C_RESET = `SWSB_CYC(`SWSB_TAR_NS),
    parameter int C_ATTN = `SWSB_CYC(`SWSB_TATTN_NS)
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe,
    input swsb_pkg::swsb_ahb_in_t ahbIn,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import swsb_pkg::*;

    localparam int NREG = 1 << IAW;
    localparam int CW = `SWSB_CNT_W;
    localparam logic [CW-1:0] LEN_ONE = CW'(`SWSB_CYC(`SWSB_TOUT1_NS));
    localparam logic [CW-1:0] LEN_ATTN = CW'(C_ATTN);

    typedef struct packed {
        swsb_fstate_t st;
        logic [4:0] cnt;
        logic [2:0] dev;
        logic [IAW-1:0] addr;
        logic rd;
        logic wide;
        logic par;
        logic ackOk;
        logic [15:0] shr;
        logic [15:0] wdat;
        logic [3:0] since;
        logic seen;
        logic berPend;
        logic funcPend;
        logic funcFlag;
        logic busErr;
        logic [2:0] myDev;
        logic wrPend;
        logic [7:0] wrAddr;
        logic [31:0] rdata;
        logic rdy;
        logic [15:0] frames;
        logic [NREG-1:0][15:0] bank;
    } swsb_slave_st_t;

    swsb_slave_st_t q, d;
    swsb_pulse_t pulse;
    logic drvGo;
    logic [CW-1:0] drvLen;
    logic drvBusy;
    logic bitIn;
    logic isBit;
    logic addrPhase;
    logic [7:0] ofs;
    logic [4:0] lastIdx;
    logic txBit;
    logic fireAttn;
    logic ackPos;
    logic [15:0] rv;

    // ------------------------------------------------------------------
    // Wire front end
    // ------------------------------------------------------------------
    swsb_pulse_meter #(
        .CW(CW),
        .CAR(C_RESET)
    ) uMeter (
        .ref_clk(ref_clk),
        .rst(rst),
        .lineIn(lineIn),
        .pulse(pulse)
    );

    swsb_low_driver #(
        .CW(CW)
    ) uDriver (
        .ref_clk(ref_clk),
        .rst(rst),
        .go(drvGo),
        .len(drvLen),
        .busy(drvBusy),
        .drvOe(lineOe)
    );

    // Wire-side read value of a register
    function automatic logic [15:0] regVal(
        input swsb_slave_st_t s,
        input logic [IAW-1:0] a
    );
        logic [15:0] v;
        v = s.bank[a];
        if (a == IAW'(`SWSB_IA_STATUS)) begin
            v = '0;
            v[`SWSB_ST_FUNC] = s.funcFlag;
            v[`SWSB_ST_BER] = s.busErr;
        end
        return v;
    endfunction : regVal

    // ------------------------------------------------------------------
    // Frame engine, attention and register bus
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        drvGo = 1'b0;
        drvLen = LEN_ONE;
        bitIn = pulse.cls == PC_ONE; // Long low reads as one
        isBit = pulse.cls == PC_ZERO || pulse.cls == PC_ONE;
        lastIdx = q.wide ? `SWSB_W16_LAST : `SWSB_W8_LAST;
        addrPhase = ahbIn.hsel && ahbIn.htrans[1] && ahbIn.hready;
        ofs = ahbIn.haddr[7:0];
        txBit = 1'b0;
        fireAttn = 1'b0;
        rv = regVal(q, q.addr);
        // Write ack is the device's own verdict, not the wire level
        ackPos = q.rd ? bitIn : q.ackOk;

        // Register bus data phase; clears land before sets below
        d.wrPend = addrPhase && ahbIn.hwrite;
        d.wrAddr = ofs;
        d.rdy = 1'b1; // Zero wait states, always OKAY
        if (q.wrPend) begin
            case (q.wrAddr)
                `SWSB_A_CTRL: begin
                    d.myDev = ahbIn.hwdata[2:0];
                end
                `SWSB_A_STAT: begin
                    if (ahbIn.hwdata[`SWSB_ST_FUNC]) d.funcFlag = 1'b0;
                    if (ahbIn.hwdata[`SWSB_ST_BER]) d.busErr = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (addrPhase && !ahbIn.hwrite) begin
            case (ofs)
                `SWSB_A_CTRL: d.rdata = {29'h0, q.myDev};
                `SWSB_A_STAT: d.rdata = {27'h0, pulse.idle, q.seen,
                    q.berPend, q.busErr, q.funcFlag};
                `SWSB_A_FRAMES: d.rdata = {16'h0, q.frames};
                default: d.rdata = 32'h0;
            endcase
        end

        // Device drive at the master's falling edge
        if (pulse.fall) begin
            if (q.st == S_DATA && q.rd) begin
                txBit = q.shr[15]; // MSB first
            end else if (q.st == S_PAR && q.rd) begin
                txBit = q.par; // Even parity after data
            end else if (q.st == S_ACK && !q.rd) begin
                txBit = q.ackOk; // Device acks writes
            end
            if (txBit && !drvBusy) begin
                drvGo = 1'b1; // Stretch master pulse to a one
            end
        end

        // Bits in a frame; attention-class pulses never reach here
        if (isBit) begin // Collided bits are simply not counted
            if (q.since != `SWSB_ATTN_BITS) begin
                d.since = q.since + 1'b1;
            end
            case (q.st)
                S_DEV: begin
                    d.dev = {q.dev[1:0], bitIn};
                    d.par = q.par ^ bitIn;
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt == 5'(`SWSB_DEV_W - 1)) begin
                        d.st = S_ADDR;
                        d.cnt = '0;
                    end
                end
                S_ADDR: begin
                    d.addr = {q.addr[IAW-2:0], bitIn};
                    d.par = q.par ^ bitIn;
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt == 5'(IAW - 1)) begin
                        d.st = S_DIR;
                        d.cnt = '0;
                    end
                end
                S_DIR: begin
                    d.rd = bitIn; // One reads, zero writes
                    d.par = q.par ^ bitIn;
                    d.wide = WIDE_MASK[q.addr]; // Length by reg
                    d.shr = WIDE_MASK[q.addr] ? rv : {rv[7:0], 8'h00};
                    d.st = S_DATA;
                    if (q.dev == `SWSB_BCAST) begin
                        if (bitIn) d.st = S_SKIP;
                        else if (q.addr != IAW'(`SWSB_IA_DEVCTL)) begin
                            d.st = S_SKIP; // Only dev control
                        end
                    end else if (q.dev != q.myDev) begin
                        d.st = S_SKIP;
                    end
                end
                S_DATA: begin
                    // Stays here until all bits come
                    d.par = q.par ^ bitIn;
                    d.shr = {q.shr[14:0], 1'b0};
                    d.wdat = {q.wdat[14:0], bitIn};
                    d.cnt = q.cnt + 1'b1;
                    if (q.cnt == lastIdx) begin
                        d.st = S_PAR;
                    end
                end
                S_PAR: begin
                    // A surplus data bit lands here as parity
                    d.ackOk = (q.par ^ bitIn) == 1'b0;
                    d.st = S_ACK;
                end
                S_ACK: begin
                    d.st = S_SKIP; // Later bits discarded
                    if (ackPos) begin
                        d.frames = q.frames + 1'b1;
                        if (q.rd && q.addr == IAW'(`SWSB_IA_STATUS)) begin
                            d.seen = 1'b0; // Acked read only
                        end
                        if (!q.rd) begin // Acked write only
                            if (q.addr == IAW'(`SWSB_IA_STATUS)) begin
                                if (q.wdat[`SWSB_ST_FUNC]) begin
                                    d.funcFlag = 1'b0;
                                end
                                if (q.wdat[`SWSB_ST_BER]) begin
                                    d.busErr = 1'b0;
                                end
                            end else if (q.wide) begin
                                d.bank[q.addr] = q.wdat;
                            end else begin
                                d.bank[q.addr] = {8'h00, q.wdat[7:0]};
                            end
                        end
                    end else begin
                        d.berPend = 1'b1; // Nack: error + attn
                    end
                end
                default: begin
                end
            endcase
        end

        // Frame start, attention seen, bus reset
        case (pulse.cls)
            PC_START: begin
                d.st = S_DEV; // Silent abort, new frame
                d.cnt = '0;
                d.par = 1'b0;
                d.dev = '0;
                d.addr = '0;
            end
            PC_ATTN: begin
                d.seen = 1'b1; // Any attention on the line
            end
            PC_RESET: begin
                d.st = S_IDLE; // Link state only, regs kept
                d.since = '0;
                d.seen = 1'b0;
                d.berPend = 1'b0;
            end
            default: begin
            end
        endcase

        // Attention request on an idle line
        if (pulse.idle && !drvBusy && q.since == `SWSB_ATTN_BITS) begin
            if (q.berPend) begin
                fireAttn = 1'b1; // Regardless of suppression
            end
            if (q.funcPend && q.bank[`SWSB_IA_DEVCTL][`SWSB_DC_ATTN]
                && !q.seen) begin
                fireAttn = 1'b1;
            end
            d.funcPend = 1'b0; // Decided at first idle
            d.berPend = 1'b0; // Waited 14 bits after reset
            if (fireAttn) begin
                drvGo = 1'b1;
                drvLen = LEN_ATTN;
            end
        end

        // Status sets win over any clear in the same cycle
        if (isBit && q.st == S_ACK && !ackPos) begin
            d.busErr = 1'b1;
        end
        if (q.wrPend && q.wrAddr == `SWSB_A_EVENT && ahbIn.hwdata[0]) begin
            d.funcFlag = 1'b1;
            d.funcPend = 1'b1; // Survives the idle decision above
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.st <= S_IDLE;
            q.myDev <= `SWSB_DEVNO_RST;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs from flip-flops or tied off (lineOut, hresp); the wire is only ever pulled low
    assign lineOut = 1'b0;
    assign hrdata = q.rdata;
    assign hreadyout = q.rdy;
    assign hresp = 1'b0;

endmodule : swsb_slave

// *** dv/swsb_slave_chk.sv ***
// Purpose: Port assertions.
// Assumes: One clock.
// Notes:   Helper counters time pulses.
`timescale 1ns/10ps
module swsb_slave_chk #(
    parameter int C_RESET = 4000,
    parameter int C_ATTN = 3000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lineIn,
    input wire logic lineOut,
    input wire logic lineOe,
    input swsb_pkg::swsb_ahb_in_t ahbIn,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    import swsb_pkg::*;
    logic [12:0] oeCnt;
    logic [12:0] loCnt;
    logic [6:0] hiCnt;
    logic [3:0] bitCnt;
    logic rdPh;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    assign rdPh = ahbIn.hsel && ahbIn.htrans[1] && !ahbIn.hwrite;

    // Pulse timers; bits counted from the end of a bus reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            oeCnt <= '0;
            loCnt <= '0;
            hiCnt <= '0;
            bitCnt <= '0;
        end else begin
            oeCnt <= lineOe ? oeCnt + 13'h1 : '0;
            loCnt <= lineIn ? '0 : loCnt + 13'(loCnt != '1);
            hiCnt <= !lineIn ? '0 : hiCnt + 7'(hiCnt != '1);
            if (lineIn && loCnt >= C_RESET)
                bitCnt <= '0;
            else if ($fell(lineIn) && !lineOe && bitCnt != 4'hf)
                bitCnt <= bitCnt + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_OPEN_DRAIN: assert property (lineOut == 1'b0)
        else $error("lineOut not low");
    AST_HOLD_LEN: assert property ($fell(lineOe) |->
        oeCnt == 13'd700 || oeCnt == C_ATTN)
        else $error("wire drive of wrong length");
    AST_EXT_IN_PULSE: assert property (
        $rose(lineOe) && !$past(lineIn) |-> loCnt < 13'd4)
        else $error("extension late in master pulse");
    AST_ATTN_IDLE: assert property (
        $rose(lineOe) && $past(lineIn) |-> hiCnt >= 7'd100)
        else $error("attention on busy wire");
    AST_NO_EARLY_ATTN: assert property (
        $rose(lineOe) && $past(lineIn) |-> bitCnt >= 4'd14)
        else $error("attention before fourteen bits");
    AST_BUS_OKAY: assert property (hresp == 1'b0 ##1 hreadyout == 1'b1)
        else $error("bus response not okay");
    AST_RDATA_HOLD: assert property (!$past(rdPh) |-> $stable(hrdata))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (
        rdPh && ahbIn.haddr[7:0] > 8'h0c |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : swsb_slave_chk

bind swsb_slave swsb_slave_chk #(.C_RESET(C_RESET), .C_ATTN(C_ATTN)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .lineIn(lineIn), .lineOut(lineOut),
    .lineOe(lineOe), .ahbIn(ahbIn), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));

// *** dv/swsb_mst_model.sv ***
// Purpose: Wire master.
// Assumes: Pull-up; mstOe pulls low.
// Notes:   Bits hit by attention are resent.
`timescale 1ns/10ps
module swsb_mst_model (
    input wire logic ref_clk,
    input wire logic lineIn,
    output logic mstOe
);
    int attnCnt = 0;
    initial mstOe = 1'b0;

    // ------------------------------------------------------------------
    // Wire tasks
    // ------------------------------------------------------------------
    // Wait for n released cycles in a row, logging attention pulses
    task automatic idle(input int n);
        int hi = 0;
        int lo = 0;
        while (hi < n) begin
            @(posedge ref_clk);
            if (lineIn) begin
                attnCnt += int'(lo >= 2500 && lo < 4000);
                hi++;
                lo = 0;
            end else begin
                lo++;
                hi = 0;
            end
        end
    endtask : idle

    // One pulse of len cycles after an inactive gap; seen is the value
    task automatic sig(input int len, output bit seen);
        int n;
        do begin
            idle(110);
            mstOe <= 1'b1;
            repeat (len) @(posedge ref_clk);
            mstOe <= 1'b0;
            n = len;
            do begin
                @(posedge ref_clk);
                n++;
            end while (!lineIn);
            attnCnt += int'(n >= 2500 && n < 4000 && len < 2500);
        end while (n >= 2500 && len < 2500);
        seen = n >= 350;
    endtask : sig
endmodule : swsb_mst_model

// *** dv/tb.sv ***
// Purpose: Bench for the wire slave.
// Assumes: Wire master model; AHB-Lite master here.
// Notes:   Model counts attention.
`timescale 1ns/10ps
`include "swsb_defs.svh"
module tb;
    import swsb_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwr = 1'b0;
    logic [1:0] htr = 2'h0;
    logic [7:0] hadr = 8'h00;
    logic [31:0] hwd = 32'h0;
    logic lineIn, lineOut, lineOe, mstOe, hreadyout, hresp;
    logic [31:0] hrdata, r;
    logic [15:0] d, d4, g;
    logic [2:0] dn = `SWSB_DEVNO_RST;
    swsb_ahb_in_t ahbIn;
    bit ok;
    int nFail = 0;
    int compares = 0;
    int seed = 32'hde36795a;

    // Released wire reads high through the pull-up
    assign lineIn = !(lineOe || mstOe);
    assign ahbIn = {hsel, 24'h0, hadr, htr, hwr, 3'h2, hwd, hreadyout};
    always #10 ref_clk = ~ref_clk;

    swsb_slave u_swsb_slave (.ref_clk(ref_clk), .rst(rst), .lineIn(lineIn),
        .lineOut(lineOut), .lineOe(lineOe), .ahbIn(ahbIn), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    swsb_mst_model mst (.ref_clk(ref_clk), .lineIn(lineIn), .mstOe(mstOe));

    // ------------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------------
    function automatic int wid(input int ia);
        return ((`SWSB_WIDE_MASK >> ia) & 1) != 0 ? 16 : 8;
    endfunction : wid

    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            nFail++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic stopTest;
        $display("compares %0d nFail %0d", compares, nFail);
        if (nFail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stopTest

    // Single word; waits on hready
    task automatic ahb(input bit wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        int t = 0;
        hsel <= 1'b1;
        htr <= 2'h2;
        hwr <= wr;
        hadr <= a;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++t < 99);
        hsel <= 1'b0;
        htr <= 2'h0;
        hwd <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++t < 99);
        rd = hrdata;
        nFail += int'(t >= 99);
    endtask : ahb

    // Checks the bus error flag, then clears it by writing one
    task automatic berCheck(input bit e);
        ahb(0, `SWSB_A_STAT, 0, r);
        chk("ber", r & 32'h2, {30'h0, e, 1'b0});
        ahb(1, `SWSB_A_STAT, 32'h2, r);
    endtask : berCheck

    // Frame into g; ok: write ack or read parity match
    task automatic xfer(input logic [2:0] dev, input logic [4:0] ia,
        input bit rd, input logic [15:0] dt, input int n, input bit bad = 0,
        input bit ack = 1, input int hold = 0, input bit quit = 0);
        logic [8:0] h;
        bit s;
        bit p;
        h = {dev, ia, rd};
        p = ^h ^ bad;
        g = 16'h0;
        mst.sig(1100, s);
        for (int i = 8; i >= 0; i--) mst.sig(h[i] ? 360 : 20, s);
        for (int i = n - 1; i >= 0; i--) begin
            mst.idle(i == n / 2 ? hold : 0);
            if (i == n / 2 && quit) return;
            mst.sig(!rd && dt[i] ? 360 : 20, s);
            g[i] = s;
            p ^= s;
        end
        mst.sig(!rd && p ? 360 : 20, s);
        ok = s == p;
        mst.sig(rd && ack ? 360 : 20, s);
        if (!rd) ok = s;
    endtask : xfer

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (300000) @(posedge ref_clk);
        nFail++;
        stopTest();
    end

    // Scenarios in order; no frame is retried by itself
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        ahb(0, `SWSB_A_FRAMES, 0, r);
        chk("frames0", r, 0);
        ahb(0, 8'h10, 0, r);
        mst.sig(4200, ok);
        repeat (8) mst.sig(20, ok);
        d4 = 16'($random(seed));
        xfer(dn, 5'h4, 0, d4, wid(4));
        chk("wack", 32'(ok), 1);
        xfer(dn, 5'h4, 1, 0, wid(4));
        chk("rdata", 32'(g), 32'(d4));
        chk("rpar", 32'(ok), 1);
        // Refused read: not counted, error flag and attention
        mst.attnCnt = 0;
        xfer(dn, 5'h4, 1, 0, 16, 0, 0);
        mst.idle(3500);
        chk("nackAttn", mst.attnCnt, 1);
        ahb(0, `SWSB_A_FRAMES, 0, r);
        chk("frames", r, 2);
        berCheck(1);
        // Bad parity write refused, word kept, attention despite no read
        mst.attnCnt = 0;
        xfer(dn, 5'h4, 0, ~d4, 16, 1);
        chk("badAck", 32'(ok), 0);
        xfer(dn, 5'h4, 1, 0, 16);
        chk("kept", 32'(g), 32'(d4));
        chk("berAttn", mst.attnCnt, 1);
        berCheck(1);
        // Ninth data bit on a byte register lands in the parity slot
        mst.attnCnt = 0;
        xfer(dn, 5'h3, 0, 16'h0, 9);
        mst.idle(3500);
        chk("xtraAttn", mst.attnCnt, 1);
        berCheck(1);
        // Long pause mid-data, then an abandoned frame
        d = 16'($random(seed)) & 16'h00ff;
        xfer(dn, 5'h3, 0, d, wid(3), 0, 1, 2000);
        chk("slowAck", 32'(ok), 1);
        mst.attnCnt = 0;
        xfer(dn, 5'h3, 0, ~d, 8, 0, 1, 2000, 1);
        xfer(dn, 5'h3, 1, 0, 8);
        chk("abort", 32'(g), 32'(d));
        xfer(3'h0, 5'h4, 1, 0, 16);
        chk("bcRd", 32'(g), 0);
        chk("quiet", mst.attnCnt, 0);
        berCheck(0);
        // Broadcast write: device control taken, other register not
        xfer(3'h0, `SWSB_IA_DEVCTL, 0, 16'h1, 8);
        xfer(3'h0, 5'h4, 0, 16'h0, 16);
        xfer(dn, `SWSB_IA_DEVCTL, 1, 0, 8);
        chk("bcCtl", 32'(g), 1);
        xfer(dn, 5'h4, 1, 0, 16);
        chk("bcOther", 32'(g), 32'(d4));
        // Status read re-arms; a second event is held back
        xfer(dn, `SWSB_IA_STATUS, 1, 0, 8);
        mst.attnCnt = 0;
        for (int k = 0; k < 2; k++) begin
            ahb(1, `SWSB_A_EVENT, 1, r);
            mst.idle(3500);
            chk("fnAttn", mst.attnCnt, 1);
        end
        ahb(0, `SWSB_A_STAT, 0, r);
        chk("fnFlag", r & 32'h1, 1);
        // Bus reset keeps registers; attention waits for 14 bits
        mst.sig(4200, ok);
        ahb(1, `SWSB_A_EVENT, 1, r);
        mst.idle(3500);
        chk("rstHold", mst.attnCnt, 1);
        repeat (8) mst.sig(20, ok);
        xfer(dn, 5'h4, 1, 0, 16);
        chk("rstKeep", 32'(g), 32'(d4));
        mst.idle(3500);
        chk("rstAttn", mst.attnCnt, 2);
        stopTest();
    end
endmodule : tb
